/* design/moncfg_regs.sv */
// primary and secondary monitor configuration registers with lock
`timescale 1ns/1ps
module moncfg_regs
	import moncfg_pkg::*;
(
	input  wire logic              CLOCK_IN,        // 125 MHz clock
	input  wire logic              NRST_IN,         // power-on reset, low
	input  wire moncfg_pkg::reg_req_s REQ_IN,       // register request
	input  wire logic              POWERED_IN,      // core fully powered
	input  wire logic              SINGLE_CH_IN,    // single channel mode
	input  wire logic [1:0]        AIN_THERM_IN,    // thermistor selects
	input  wire logic [7:0]        DAC1_IN,         // fan 1 drive request
	input  wire logic [7:0]        DAC2_IN,         // fan 2 drive request
	output logic [7:0]             RDATA_OUT,       // read data
	output logic                   RVALID_OUT,      // read data valid
	output logic                   LOCKED_OUT,      // freeze active
	output logic [7:0]             DAC1_OUT,        // fan 1 drive / readback
	output logic [7:0]             DAC2_OUT,        // fan 2 drive / readback
	output logic                   REF_O_OUT,       // reference pin value
	output logic                   REF_OE_OUT,      // reference pin enable
	output moncfg_pkg::ctrl_s      CTRL_OUT         // decoded controls
);
	import moncfg_pkg::*;

	logic [7:0] pri_r;      // primary storage
	logic [7:0] pri_nxt;    // primary next
	logic [7:0] sec_r;      // secondary storage
	logic [7:0] sec_nxt;    // secondary next
	logic       rdy_r;      // powered-up flag
	logic       rdy_nxt;    // flag next
	logic [7:0] rdata_r;    // read data flop
	logic [7:0] rdata_nxt;  // read data next
	logic       rvalid_r;   // read valid flop
	logic [7:0] dac1_r;     // fan 1 output flop
	logic [7:0] dac2_r;     // fan 2 output flop
	logic       locked;     // freeze flag
	logic       wr_pri;     // write hits primary
	logic       wr_sec;     // write hits secondary
	logic       lock_set;   // write of a one to lock
	logic [7:0] pri_we;     // primary bit enables
	logic [7:0] sec_we;     // secondary bit enables
	logic [7:0] pri_view;   // primary as read
	logic [7:0] sec_view;   // secondary as read
	ain_mode_e  ain_mode [N_AIN]; // input modes
	conv_mode_e conv_mode;  // pacing decode

	// address decode
	assign wr_pri   = REQ_IN.wr && (REQ_IN.addr == OFF_PRI);
	assign wr_sec   = REQ_IN.wr && (REQ_IN.addr == OFF_SEC);
	assign lock_set = wr_pri && REQ_IN.data[B_LOCK];

	assign pri_we = wr_pri ? (PRI_WR_MASK & ~(locked ? PRI_LOCK_MASK : 8'h00))
	                       : 8'h00;
	assign sec_we = (wr_sec && !locked) ? SEC_WR_MASK : 8'h00;

	assign pri_nxt = (pri_r & ~pri_we) | (REQ_IN.data & pri_we);
	assign sec_nxt = (sec_r & ~sec_we) | (REQ_IN.data & sec_we);

	assign rdy_nxt = rdy_r | POWERED_IN;

	// primary read view merges status bits, secondary reads as stored
	assign pri_view = pri_r | {5'h00, rdy_r, locked, 1'b0};
	assign sec_view = sec_r;

	// read mux, unmapped reads zero
	assign rdata_nxt = (REQ_IN.addr == OFF_PRI) ? pri_view :
	                   (REQ_IN.addr == OFF_SEC) ? sec_view : 8'h00;

	// freeze flag
	moncfg_lock i_moncfg_lock (
		.clk_in     (CLOCK_IN),
		.nrst_in    (NRST_IN),
		.set_in     (lock_set),
		.locked_out (locked)
	);

	// analog input configuration
	moncfg_ain i_moncfg_ain (
		.clk_in    (CLOCK_IN),
		.nrst_in   (NRST_IN),
		.diode2_in (sec_r[B_DIODE2]),
		.therm_in  (AIN_THERM_IN),
		.mode_out  (ain_mode)
	);

	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			pri_r <= PRI_RESET;
			sec_r <= SEC_RESET;
			rdy_r <= 1'b0;
		end else begin
			pri_r <= pri_nxt;
			sec_r <= sec_nxt;
			rdy_r <= rdy_nxt;
		end
	end

	// read answer one cycle after strobe
	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			rdata_r  <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= REQ_IN.rd;
			if (REQ_IN.rd) begin
				rdata_r <= rdata_nxt;
			end
		end
	end

	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			dac1_r <= DAC_OFF;
			dac2_r <= DAC_OFF;
		end else begin
			dac1_r <= sec_r[B_PDOWN] ? DAC_OFF : DAC1_IN;
			dac2_r <= sec_r[B_PDOWN] ? DAC_OFF : DAC2_IN;
		end
	end

	// pacing decode from averaging, single channel mode and rate
	always_comb begin
		case ({sec_r[B_AVGOFF], SINGLE_CH_IN})
			2'b00, 2'b01: conv_mode = CONV_AVERAGED;
			// averaging off, scanning all
			2'b10: conv_mode = CONV_FAST;
			2'b11: conv_mode = sec_r[B_RATE] ? CONV_SLOW4 : CONV_FAST32;
			default: conv_mode = CONV_AVERAGED;
		endcase
	end

	assign CTRL_OUT.use_prog_limits = pri_r[B_START];
	assign CTRL_OUT.fans_full       = pri_r[B_FULL];
	assign CTRL_OUT.spinup_drive    = pri_r[B_SPINUP];
	assign CTRL_OUT.timeout_off     = pri_r[B_TIMEOUT];
	assign CTRL_OUT.supply_5v       = pri_r[B_SUPPLY];
	assign CTRL_OUT.offset_binary   = pri_r[B_FORMAT];
	assign CTRL_OUT.therm_10k       = sec_r[B_THERMISTOR_VALUE_SELECT];
	// excitation current, host keeps it zero
	assign CTRL_OUT.diode_current   = sec_r[B_DIODE_CURRENT_SELECT];
	assign CTRL_OUT.power_down      = sec_r[B_PDOWN];
	assign CTRL_OUT.conv_mode       = conv_mode;
	assign CTRL_OUT.ain_a_mode      = ain_mode[0];
	assign CTRL_OUT.ain_b_mode      = ain_mode[1];

	assign REF_OE_OUT = !sec_r[B_REFF];
	assign REF_O_OUT  = 1'b1;

	// port drives
	assign RDATA_OUT  = rdata_r;
	assign RVALID_OUT = rvalid_r;
	assign LOCKED_OUT = locked;
	assign DAC1_OUT   = dac1_r;
	assign DAC2_OUT   = dac2_r;

	// checks, one clock domain
	default clocking cb @(posedge CLOCK_IN);
	endclocking
	default disable iff (!NRST_IN);

	property p_reset_vals;
		$rose(NRST_IN) |-> (pri_r == PRI_RESET) && (sec_r == SEC_RESET);
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("power-on values wrong");

	property p_start_frozen;
		locked && wr_pri |=> $stable(pri_r[B_START]);
	endproperty
	a_start_frozen: assert property (p_start_frozen)
		else $error("start bit changed while locked");

	property p_lock_sticky;
		LOCKED_OUT |=> LOCKED_OUT [*3];
	endproperty
	a_lock_sticky: assert property (p_lock_sticky)
		else $error("lock cleared without reset");

	property p_lock_sets;
		wr_pri && REQ_IN.data[B_LOCK] |=> LOCKED_OUT;
	endproperty
	a_lock_sets: assert property (p_lock_sets)
		else $error("lock write did not take");

	property p_ready;
		POWERED_IN |=> rdy_r ##1 rdy_r;
	endproperty
	a_ready: assert property (p_ready)
		else $error("ready flag not held");

	property p_full_writable;
		wr_pri |=> pri_r[B_FULL] == $past(REQ_IN.data[B_FULL]);
	endproperty
	a_full_writable: assert property (p_full_writable)
		else $error("full speed bit not written");

	property p_sec_frozen;
		locked |=> $stable(sec_r);
	endproperty
	a_sec_frozen: assert property (p_sec_frozen)
		else $error("secondary changed while locked");

	property p_unused_zero;
		RVALID_OUT && $past(REQ_IN.addr) == OFF_SEC |-> !RDATA_OUT[B_UNUSED];
	endproperty
	a_unused_zero: assert property (p_unused_zero)
		else $error("unused bit read nonzero");

	property p_ref_float;
		sec_r[B_REFF] |-> !REF_OE_OUT;
	endproperty
	a_ref_float: assert property (p_ref_float)
		else $error("reference driven while floated");

	property p_shutdown;
		sec_r[B_PDOWN] |=> (DAC1_OUT == DAC_OFF) && (DAC2_OUT == DAC_OFF);
	endproperty
	a_shutdown: assert property (p_shutdown)
		else $error("fan drive not zero in shutdown");

	property p_rate;
		sec_r[B_AVGOFF] && SINGLE_CH_IN |->
			CTRL_OUT.conv_mode == (sec_r[B_RATE] ? CONV_SLOW4 : CONV_FAST32);
	endproperty
	a_rate: assert property (p_rate)
		else $error("conversion rate wrong");

	property p_diode2;
		sec_r[B_DIODE2] |=> CTRL_OUT.ain_a_mode == AIN_DIODE
			&& CTRL_OUT.ain_b_mode == AIN_DIODE;
	endproperty
	a_diode2: assert property (p_diode2)
		else $error("second diode not selected");

	// start bit takes a free write
	property p_start_follows;
		wr_pri && !locked |=>
			CTRL_OUT.use_prog_limits == $past(REQ_IN.data[B_START]);
	endproperty
	a_start_follows: assert property (p_start_follows)
		else $error("start bit not applied");

	// freeze flag visible in primary reads
	property p_lock_readback;
		RVALID_OUT && $past(REQ_IN.addr) == OFF_PRI |->
			RDATA_OUT[B_LOCK] == $past(LOCKED_OUT);
	endproperty
	a_lock_readback: assert property (p_lock_readback)
		else $error("lock bit read back wrong");

	// ready flag visible in primary reads
	property p_ready_readback;
		RVALID_OUT && $past(REQ_IN.addr) == OFF_PRI |->
			RDATA_OUT[B_READY] == $past(rdy_r);
	endproperty
	a_ready_readback: assert property (p_ready_readback)
		else $error("ready bit read back wrong");

	// timeout disable frozen by lock
	property p_timeout_locked;
		locked && wr_pri |=> $stable(pri_r[B_TIMEOUT]);
	endproperty
	a_timeout_locked: assert property (p_timeout_locked)
		else $error("timeout bit changed while locked");

	// supply scaling frozen by lock
	property p_supply_locked;
		locked && wr_pri |=> $stable(pri_r[B_SUPPLY]);
	endproperty
	a_supply_locked: assert property (p_supply_locked)
		else $error("supply bit changed while locked");

	// format bit takes every write
	property p_format;
		wr_pri |=> CTRL_OUT.offset_binary == $past(REQ_IN.data[B_FORMAT]);
	endproperty
	a_format: assert property (p_format)
		else $error("format bit not applied");

	// spin-up option takes every write
	property p_spinup;
		wr_pri |=> CTRL_OUT.spinup_drive == $past(REQ_IN.data[B_SPINUP]);
	endproperty
	a_spinup: assert property (p_spinup)
		else $error("spin-up bit not applied");

	// thermistor scaling takes a free write
	property p_therm_type;
		wr_sec && !locked |=> CTRL_OUT.therm_10k == $past(REQ_IN.data[B_THERMISTOR_VALUE_SELECT]);
	endproperty
	a_therm_type: assert property (p_therm_type)
		else $error("thermistor type not applied");

	// averaging on forces normal pace
	property p_avg_on;
		!sec_r[B_AVGOFF] |-> CTRL_OUT.conv_mode == CONV_AVERAGED;
	endproperty
	a_avg_on: assert property (p_avg_on)
		else $error("pacing wrong with averaging on");

	// averaging off while scanning all inputs
	property p_fast_scan;
		sec_r[B_AVGOFF] && !SINGLE_CH_IN |-> CTRL_OUT.conv_mode == CONV_FAST;
	endproperty
	a_fast_scan: assert property (p_fast_scan)
		else $error("pacing wrong with averaging off");

	// thermistor or voltage without second diode
	property p_ain_therm;
		!sec_r[B_DIODE2] |=>
			CTRL_OUT.ain_a_mode == ($past(AIN_THERM_IN[0]) ? AIN_THERMISTOR : AIN_VOLTAGE)
			&& CTRL_OUT.ain_b_mode == ($past(AIN_THERM_IN[1]) ? AIN_THERMISTOR : AIN_VOLTAGE);
	endproperty
	a_ain_therm: assert property (p_ain_therm)
		else $error("input mode wrong");

	// every read is answered, locked or not
	property p_read_answer;
		REQ_IN.rd |=> RVALID_OUT;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read not answered");

	// fan drive passes through when running
	property p_dac_follow;
		!sec_r[B_PDOWN] |=> DAC1_OUT == $past(DAC1_IN) && DAC2_OUT == $past(DAC2_IN);
	endproperty
	a_dac_follow: assert property (p_dac_follow)
		else $error("fan drive not passed through");

	// unused bit never stored
	property p_unused_clear;
		!sec_r[B_UNUSED];
	endproperty
	a_unused_clear: assert property (p_unused_clear)
		else $error("unused bit stored");

	c_lock: cover property ($rose(LOCKED_OUT));
	c_locked_wr: cover property (locked && wr_sec);
	c_shutdown: cover property (sec_r[B_PDOWN] && DAC1_IN != DAC_OFF);
	c_diode2: cover property (sec_r[B_DIODE2] && AIN_THERM_IN != 2'b00);
	c_ready: cover property ($rose(rdy_r));
endmodule : moncfg_regs

/* design/moncfg_pkg.sv */
// constants, types and field layout of the monitor configuration bank
// Operation
// - primary resets 0x01, secondary resets 0x00
// - start set: programmed limits drive monitoring
// - start clear: default limits, values kept
// - lock freezes the start bit
// - lock is write once until power cycle
// - ready flag set once powered up
// - full speed bit always writable, forces fans
// - spin-up pulse detect off, drive high
// - bus timeout disable bit, lockable
// - supply scaling 5 V or 3.3 V, lockable
// - temperature format binary or offset binary
// - secondary register frozen while locked
// - thermistor normalization 100k or 10k
// - reference pin floats when bit set
// - secondary bit 3 ignores writes, reads 0
// - averaging off speeds up conversions
// - fast single channel rate 32 or 4
// - power down zeroes both fan drives
// - second diode overrides thermistor selects
// - thermistor select: thermistor or voltage input
package moncfg_pkg;
	localparam logic [7:0] OFF_PRI       = 8'h00; // primary offset
	localparam logic [7:0] OFF_SEC       = 8'h01; // secondary offset
	localparam logic [7:0] PRI_RESET     = 8'h01; // primary power-on value
	localparam logic [7:0] SEC_RESET     = 8'h00; // secondary power-on value
	localparam logic [7:0] PRI_WR_MASK   = 8'hF9; // bits stored from writes
	localparam logic [7:0] PRI_LOCK_MASK = 8'h61; // bits frozen by lock
	localparam logic [7:0] SEC_WR_MASK   = 8'hF7; // bit 3 never stored
	localparam logic [7:0] DAC_OFF       = 8'h00; // fan drive in shutdown
	// primary field positions
	localparam int B_START   = 0; // monitor_start
	localparam int B_LOCK    = 1; // limit_freeze
	localparam int B_READY   = 2; // powered_up_flag
	localparam int B_FULL    = 3; // all_fans_full
	localparam int B_SPINUP  = 4; // spinup_pulse_disable
	localparam int B_TIMEOUT = 5; // bus_timeout_disable
	localparam int B_SUPPLY  = 6; // supply_range_select
	localparam int B_FORMAT  = 7; // temp_format_select
	// secondary field positions
	localparam int B_THERMISTOR_VALUE_SELECT  = 0; // thermistor_value_select
	localparam int B_DIODE_CURRENT_SELECT   = 1; // diode_current_select
	localparam int B_REFF   = 2; // ref_output_float
	localparam int B_UNUSED = 3; // unused, reads zero
	localparam int B_AVGOFF = 4; // averaging_off
	localparam int B_RATE   = 5; // slow rate select
	localparam int B_PDOWN  = 6; // power_down_mode
	localparam int B_DIODE2 = 7; // second_diode_select
	localparam int N_AIN    = 2; // analog inputs
	// conversion pacing
	typedef enum logic [1:0] {
		CONV_AVERAGED = 2'b00, // averaged, normal pace
		CONV_FAST32   = 2'b01, // 32 conversions per second
		CONV_SLOW4    = 2'b10, // 4 conversions per second
		CONV_FAST     = 2'b11  // averaging off, multi channel
	} conv_mode_e;
	// analog input configuration
	typedef enum logic [1:0] {
		AIN_VOLTAGE    = 2'b00, // plain voltage input
		AIN_THERMISTOR = 2'b01, // thermistor input
		AIN_DIODE      = 2'b10  // second thermal diode
	} ain_mode_e;
	// register access request
	typedef struct packed {
		logic       wr;   // write strobe, one cycle
		logic       rd;   // read strobe, one cycle
		logic [7:0] addr; // register offset
		logic [7:0] data; // write data
	} reg_req_s;
	// decoded controls to the monitor core
	typedef struct packed {
		logic       use_prog_limits; // programmed limits active
		logic       fans_full;       // all fans full speed
		logic       spinup_drive;    // spin-up by timeout only
		logic       timeout_off;     // bus timeout disabled
		logic       supply_5v;       // supply scaled for 5 V
		logic       offset_binary;   // temperature format
		logic       therm_10k;       // 10k thermistor scaling
		logic       diode_current;   // diode excitation select
		logic       power_down;      // shutdown mode
		conv_mode_e conv_mode;       // conversion pacing
		ain_mode_e  ain_a_mode;      // analog_input_a setup
		ain_mode_e  ain_b_mode;      // analog_input_b setup
	} ctrl_s;
endpackage : moncfg_pkg

/* design/moncfg_lock.sv */
// write-once freeze flag, cleared only by power-on reset
`timescale 1ns/1ps
module moncfg_lock (
	input  wire logic clk_in,    // clock
	input  wire logic nrst_in,   // power-on reset, low
	input  wire logic set_in,    // write of a one
	output logic      locked_out // freeze active
);
	// once set, nothing but reset clears it
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			locked_out <= 1'b0;
		end else if (set_in) begin
			locked_out <= 1'b1;
		end
	end
endmodule : moncfg_lock

/* design/moncfg_ain.sv */
// per-input analog configuration, second diode has priority
`timescale 1ns/1ps
module moncfg_ain
	import moncfg_pkg::*;
(
	input  wire logic             clk_in,     // clock
	input  wire logic             nrst_in,    // reset, low
	input  wire logic             diode2_in,  // second diode select
	input  wire logic [N_AIN-1:0] therm_in,   // thermistor selects
	output ain_mode_e             mode_out [N_AIN] // per-input mode
);
	// one mode flop per input
	for (genvar i = 0; i < N_AIN; i++) begin : g_ain
		ain_mode_e mode_nxt; // next mode
		assign mode_nxt = diode2_in   ? AIN_DIODE :
		                  therm_in[i] ? AIN_THERMISTOR : AIN_VOLTAGE;
		always_ff @(posedge clk_in or negedge nrst_in) begin
			if (!nrst_in) begin
				mode_out[i] <= AIN_VOLTAGE;
			end else begin
				mode_out[i] <= mode_nxt;
			end
		end
	end
endmodule : moncfg_ain

/* verif/moncfg_host.sv */
// host model issuing register reads and writes
`timescale 1ns/1ps
module moncfg_host (
	input  wire logic             clk_in,    // clock
	input  wire logic             rvalid_in, // read data valid
	input  wire logic [7:0]       rdata_in,  // read data
	output moncfg_pkg::reg_req_s  req_out    // register request
);
	import moncfg_pkg::*;
	initial req_out = '0;
	// drop strobes, scramble stale lines
	task automatic idle();
		req_out.wr = 1'b0;
		req_out.rd = 1'b0;
		req_out.addr = ~req_out.addr;
		req_out.data = ~req_out.data;
	endtask : idle
	// one write, held over one rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		req_out = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
		@(negedge clk_in);
		idle();
	endtask : wr
	// one read, answer due one cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
		@(negedge clk_in);
		req_out = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
		@(negedge clk_in);
		ok = (rvalid_in === 1'b1);
		d = rdata_in;
		idle();
	endtask : rd
endmodule : moncfg_host

/* verif/testbench.sv */
// self-checking bench for the monitor configuration bank
`timescale 1ns/1ps
module testbench;
	import moncfg_pkg::*;
	logic       clk = 1'b0;      // clock
	logic       nrst = 1'b0;     // reset, low
	logic       powered = 1'b0;  // core powered
	logic       single = 1'b0;   // single channel
	logic [1:0] therm = 2'b00;   // thermistor selects
	logic [7:0] dac1 = 8'h5A;    // fan 1 request
	logic [7:0] dac2 = 8'hA5;    // fan 2 request
	reg_req_s   req;             // host request
	logic [7:0] rdata, dac1_o, dac2_o;
	logic       rvalid, locked, ref_o, ref_oe;
	ctrl_s      ctrl;            // decoded controls
	int         errors = 0;      // mismatches
	int         num_checks = 0;  // comparisons
	// packed views of the controls
	wire [7:0] pri_ctl = {2'b00, ctrl.offset_binary, ctrl.supply_5v, ctrl.timeout_off,
		ctrl.spinup_drive, ctrl.fans_full, ctrl.use_prog_limits};
	wire [7:0] sec_ctl = {2'b00, ctrl.power_down, ctrl.diode_current, ctrl.therm_10k,
		ref_oe, ctrl.conv_mode};
	wire [7:0] ain_ctl = {4'h0, ctrl.ain_b_mode, ctrl.ain_a_mode};
	always #4 clk = ~clk;
	moncfg_regs i_moncfg_regs (.CLOCK_IN(clk), .NRST_IN(nrst), .REQ_IN(req),
		.POWERED_IN(powered), .SINGLE_CH_IN(single), .AIN_THERM_IN(therm),
		.DAC1_IN(dac1), .DAC2_IN(dac2), .RDATA_OUT(rdata), .RVALID_OUT(rvalid),
		.LOCKED_OUT(locked), .DAC1_OUT(dac1_o), .DAC2_OUT(dac2_o), .REF_O_OUT(ref_o),
		.REF_OE_OUT(ref_oe), .CTRL_OUT(ctrl));
	moncfg_host i_moncfg_host (.clk_in(clk), .rvalid_in(rvalid), .rdata_in(rdata),
		.req_out(req));
	// compare and count
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// read a register and compare
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		bit         ok;
		i_moncfg_host.rd(a, d, ok);
		chk("rvalid", 8'h01, {7'h00, ok});
		chk($sformatf("reg %h", a), e, d);
	endtask : rdchk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_moncfg_host.wr(a, d);
	endtask : wr
	// verdict and end of run
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	// hang guard
	initial begin
		#200000;
		errors++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		repeat (8) @(negedge clk);
		nrst = 1'b1;
		rdchk(OFF_PRI, PRI_RESET);
		rdchk(OFF_SEC, SEC_RESET);
		chk("locked", 8'h00, {7'h00, locked});
		powered = 1'b1;
		repeat (2) @(negedge clk);
		rdchk(OFF_PRI, 8'h05);
		// limits would be programmed here, before start
		wr(OFF_PRI, 8'hF9);
		chk("pri ctl", 8'h3F, pri_ctl);
		rdchk(OFF_PRI, 8'hFD);
		wr(OFF_PRI, 8'h00);
		chk("pri ctl", 8'h00, pri_ctl);
		rdchk(OFF_PRI, 8'h04);
		// diode current bit kept clear by the host
		therm = 2'b11;
		single = 1'b1;
		wr(OFF_SEC, 8'hFD);
		rdchk(OFF_SEC, 8'hF5);
		chk("sec ctl", 8'h2A, sec_ctl);
		chk("ain", 8'h0A, ain_ctl);
		chk("dac1", DAC_OFF, dac1_o);
		chk("dac2", DAC_OFF, dac2_o);
		chk("ref_o", 8'h01, {7'h00, ref_o});
		wr(OFF_SEC, 8'h10);
		rdchk(OFF_SEC, 8'h10);
		chk("sec ctl", 8'h05, sec_ctl);
		chk("ain", 8'h05, ain_ctl);
		chk("dac1", 8'h5A, dac1_o);
		chk("dac2", 8'hA5, dac2_o);
		single = 1'b0;
		therm = 2'b10;
		@(negedge clk);
		chk("sec ctl", 8'h07, sec_ctl);
		wr(OFF_SEC, 8'h01);
		rdchk(OFF_SEC, 8'h01);
		chk("sec ctl", 8'h0C, sec_ctl);
		chk("ain", 8'h04, ain_ctl);
		// set the freeze, then try to change frozen bits
		wr(OFF_PRI, 8'h03);
		chk("locked", 8'h01, {7'h00, locked});
		rdchk(OFF_PRI, 8'h07);
		wr(OFF_PRI, 8'h68);
		rdchk(OFF_PRI, 8'h0F);
		wr(OFF_SEC, 8'hF0);
		rdchk(OFF_SEC, 8'h01);
		wr(OFF_PRI, 8'h00);
		rdchk(OFF_PRI, 8'h07);
		rdchk(8'h02, 8'h00);
		// only a power-on reset clears the freeze
		@(negedge clk);
		nrst = 1'b0;
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		chk("locked", 8'h00, {7'h00, locked});
		rdchk(OFF_PRI, 8'h05);
		rdchk(OFF_SEC, SEC_RESET);
		tally_and_finish();
	end
endmodule : testbench
